/* design/tmc_pkg.sv */
package tmc_pkg;

   // register map, byte offsets on the serial register port
   localparam logic [7:0] ADDR_TEMP_BASE = 8'h00;
   localparam logic [7:0] ADDR_TEMP_LAST = 8'h03;
   localparam logic [7:0] ADDR_HIGHEST = 8'h10;
   localparam logic [7:0] ADDR_SEL = 8'h12;
   localparam logic [7:0] ADDR_CFG = 8'h13;
   localparam logic [7:0] ADDR_LIM_BASE = 8'h20;
   localparam logic [7:0] ADDR_LIM_LAST = 8'h27;
   localparam logic [7:0] ADDR_STAT_HI = 8'h32;
   localparam logic [7:0] ADDR_STAT_LO = 8'h33;
   localparam logic [7:0] ADDR_MASK = 8'h34;

   // configuration fields
   localparam int unsigned CFG_STOP = 7;
   localparam int unsigned CFG_POR = 6;
   localparam int unsigned CFG_TMO = 5;
   localparam int unsigned CFG_CMP = 4;
   localparam int unsigned CFG_FQ_HI = 3;
   localparam int unsigned CFG_FQ_LO = 2;
   localparam int unsigned CFG_WIDE = 1;
   localparam int unsigned CFG_ONESHOT = 0;

   localparam int unsigned NUM_CH = 4;
   localparam int unsigned NUM_LIM = 8;

   // reset values
   localparam logic [7:0] SEL_RST = 8'hFF;
   localparam logic [7:0] SEL_RSVD = 8'hF0;
   localparam logic [7:0] CFG_RST = 8'h10;
   localparam logic [7:0] CFG_SELF_CLR = 8'h41;
   localparam logic [3:0] MASK_RST = 4'hF;
   localparam logic [7:0] LIM_HI_RST = 8'h7F;
   localparam logic [7:0] LIM_LO_RST = 8'h80;
   localparam logic [7:0] TEMP_RST = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // temperature coding, whole degrees
   localparam logic [9:0] WIDE_OFFSET = 10'h040;
   localparam logic signed [9:0] ENC_MAX = 10'h07F;
   localparam logic signed [9:0] ENC_MIN = 10'h380;
   localparam logic [7:0] TEMP_MIN = 8'h80;
   localparam logic signed [8:0] HYST = 9'h002;

   // fault queue depths per code
   localparam logic [2:0] FQ_D0 = 3'h1;
   localparam logic [2:0] FQ_D1 = 3'h2;
   localparam logic [2:0] FQ_D2 = 3'h4;
   localparam logic [2:0] FQ_D3 = 3'h6;
   localparam logic [2:0] CNT_ONE = 3'h1;
   localparam logic [2:0] CNT_ZERO = 3'h0;

   typedef enum logic [0:0] {
      TMC_ST_IDLE = 1'b0,
      TMC_ST_WAIT = 1'b1
   } tmc_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tmc_reg_req_t;

   typedef struct packed {
      logic done;
      logic [NUM_CH-1:0][8:0] temp;
   } tmc_conv_t;

endpackage : tmc_pkg

/* design/tmc_limit_mem.sv */
`timescale 1ns/1ps

module tmc_limit_mem (
   input wire logic sys_clk_i, // system clock
   input wire logic clear_i, // return all words to power-on values
   input wire logic we_i, // write strobe
   input wire logic [2:0] waddr_i, // write word index
   input wire logic [7:0] wdata_i, // write data
   input wire logic [2:0] raddr_i, // read word index
   output logic [7:0] rdata_o, // registered read data
   output logic [tmc_pkg::NUM_LIM-1:0][7:0] words_o // all words
);

   logic [tmc_pkg::NUM_LIM-1:0][7:0] mem_q;

   // high limits occupy the lower half, low limits the upper half
   always_ff @(posedge sys_clk_i) begin
      for (int i = 0; i < tmc_pkg::NUM_LIM; i++) begin
         if (clear_i) begin
            mem_q[i] <= (i < tmc_pkg::NUM_CH) ? tmc_pkg::LIM_HI_RST
                                              : tmc_pkg::LIM_LO_RST;
         end else if (we_i && waddr_i == 3'(i)) begin
            mem_q[i] <= wdata_i;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (clear_i) begin
         rdata_o <= tmc_pkg::READ_ZERO;
      end else begin
         rdata_o <= mem_q[raddr_i];
      end
   end

   assign words_o = mem_q;

endmodule : tmc_limit_mem

/* design/tmc_regs.sv */
// Operation
// R01 - only channels with select bit 1 take part in highest search
// R02 - eight host read/write limit bytes hold high and low thresholds
// R03 - all alarms start masked after power-up until host unmasks
// R04 - threshold crossing sets that channel's thermal status bit
// R05 - crossing also asserts alarm pin unless channel masked
// R06 - config bit 7 one stops converter, zero runs continuously
// R07 - register port stays fully working during standby
// R08 - config bit 6 resets every register, then clears itself
// R09 - config bit 5 zero keeps bus timeout, one disables it
// R10 - config bit 4 one comparator, zero interrupt; resets to one
// R11 - bits 3:2 pick consecutive fault count 1, 2, 4 or 6
// R12 - config bit 1 selects the wide range data format
// R13 - config bit 0 write starts one pass, then reads zero
// R14 - a one-shot write ignores all other configuration bits
// R15 - one-shot honoured only in standby; host requests it there
// R16 - wide format stores true temperature minus 64 degrees
// R17 - host rewrites limits after format change; no conversion done
// R18 - comparator alarm releases only 2 degrees inside the limit
// R19 - interrupt alarm clears on status read or ARA, re-asserts later
// R20 - select register upper bits read one, writes to them ignored
// R21 - outside standby passes repeat back to back, updating each time
`timescale 1ns/1ps

module tmc_regs (
   input wire logic sys_clk_i, // 250 MHz system clock
   input wire logic reset_i, // synchronous power-on reset
   input wire tmc_pkg::tmc_reg_req_t req_i, // byte request from serial engine
   input wire logic ara_i, // pulse: alert response answered
   input wire tmc_pkg::tmc_conv_t conv_i, // pass results from converter
   output logic [7:0] rdata_o, // read data
   output logic rvalid_o, // pulse: rdata_o valid
   output logic conv_start_o, // pulse: begin one pass
   output logic adc_enable_o, // converter powered
   output logic timeout_en_o, // serial engine applies bus timeout
   output logic wide_range_format_o, // wide range coding in use
   output logic thermal_alarm_out_o, // open-drain data, always low
   output logic thermal_alarm_out_oe_o // high pulls the alarm pin low
);

   localparam int unsigned N = tmc_pkg::NUM_CH;

   function automatic logic [7:0] encode(input logic [8:0] t,
                                         input logic wide);
      logic signed [9:0] v;
      v = wide ? $signed({t[8], t} - tmc_pkg::WIDE_OFFSET)
               : $signed({t[8], t});
      if (v > tmc_pkg::ENC_MAX) begin
         return tmc_pkg::ENC_MAX[7:0];
      end else if (v < tmc_pkg::ENC_MIN) begin
         return tmc_pkg::ENC_MIN[7:0];
      end
      return v[7:0];
   endfunction : encode

   function automatic logic [2:0] fq_depth(input logic [1:0] code);
      case (code)
         2'h0: return tmc_pkg::FQ_D0;
         2'h1: return tmc_pkg::FQ_D1;
         2'h2: return tmc_pkg::FQ_D2;
         default: return tmc_pkg::FQ_D3;
      endcase
   endfunction : fq_depth

   function automatic logic sgt(input logic [7:0] a, input logic [7:0] b);
      return $signed(a) > $signed(b);
   endfunction : sgt

   logic soft_rst_q;
   logic rst;
   logic [7:0] cfg_q;
   logic [3:0] sel_q;
   logic [3:0] mask_q;
   logic [N-1:0][7:0] temp_q;
   logic [N-1:0][7:0] temp_d;
   logic [7:0] highest_q;
   logic [7:0] highest_d;
   logic [N-1:0] stat_hi_q;
   logic [N-1:0] stat_lo_q;
   logic [N-1:0] cmp_hi_q;
   logic [N-1:0] cmp_lo_q;
   logic [N-1:0] cmp_hi_d;
   logic [N-1:0] cmp_lo_d;
   logic [N-1:0][2:0] cnt_hi_q;
   logic [N-1:0][2:0] cnt_lo_q;
   logic [N-1:0][2:0] cnt_hi_d;
   logic [N-1:0][2:0] cnt_lo_d;
   logic [N-1:0] qual_hi;
   logic [N-1:0] qual_lo;
   logic oneshot_pend_q;
   logic alarm_q;
   logic alarm_d;
   tmc_pkg::tmc_state_t state_q;
   logic rd_d1_q;
   logic [7:0] addr_d1_q;
   logic [N-1:0][7:0] sel_temp;
   logic [tmc_pkg::NUM_LIM-1:0][7:0] lim;
   logic [7:0] lim_rdata;
   logic [7:0] rd_mux;

   wire wr_cfg = req_i.wr && req_i.addr == tmc_pkg::ADDR_CFG;
   wire wr_sel = req_i.wr && req_i.addr == tmc_pkg::ADDR_SEL;
   wire wr_mask = req_i.wr && req_i.addr == tmc_pkg::ADDR_MASK;
   wire hit_lim = req_i.addr >= tmc_pkg::ADDR_LIM_BASE &&
                  req_i.addr <= tmc_pkg::ADDR_LIM_LAST;
   wire wr_lim = req_i.wr && hit_lim;
   wire rd_stat_hi = req_i.rd && req_i.addr == tmc_pkg::ADDR_STAT_HI;
   wire rd_stat_lo = req_i.rd && req_i.addr == tmc_pkg::ADDR_STAT_LO;
   wire oneshot_wr = wr_cfg && req_i.wdata[tmc_pkg::CFG_ONESHOT];
   wire stop = cfg_q[tmc_pkg::CFG_STOP];
   wire wide = cfg_q[tmc_pkg::CFG_WIDE];
   wire cmp_mode = cfg_q[tmc_pkg::CFG_CMP];
   wire [2:0] depth = fq_depth(cfg_q[tmc_pkg::CFG_FQ_HI:tmc_pkg::CFG_FQ_LO]);
   wire pass_done = state_q == tmc_pkg::TMC_ST_WAIT && conv_i.done;
   wire start_pass = state_q == tmc_pkg::TMC_ST_IDLE &&
                     (!stop || oneshot_pend_q); // [R06] [R21] [R13]
   wire [7:0] cfg_wr_val = req_i.wdata & ~tmc_pkg::CFG_SELF_CLR;

   // a soft reset is taken one cycle after the write so the whole bank
   // including this bit falls back together
   assign rst = reset_i || soft_rst_q; // [R08]

   tmc_limit_mem u_lim (
      .sys_clk_i(sys_clk_i),
      .clear_i(rst),
      .we_i(wr_lim), // [R02]
      .waddr_i(req_i.addr[2:0]),
      .wdata_i(req_i.wdata),
      .raddr_i(req_i.addr[2:0]),
      .rdata_o(lim_rdata),
      .words_o(lim)
   );

   // per-channel compare, fault queue and comparator hysteresis
   always_comb begin
      for (int c = 0; c < N; c++) begin
         temp_d[c] = encode(conv_i.temp[c], wide); // [R12] [R16]
         cnt_hi_d[c] = cnt_hi_q[c];
         cnt_lo_d[c] = cnt_lo_q[c];
         cmp_hi_d[c] = cmp_hi_q[c];
         cmp_lo_d[c] = cmp_lo_q[c];
         qual_hi[c] = 1'b0;
         qual_lo[c] = 1'b0;
         if (pass_done) begin
            if (sgt(temp_d[c], lim[c])) begin
               if (cnt_hi_q[c] < tmc_pkg::FQ_D3) begin
                  cnt_hi_d[c] = cnt_hi_q[c] + tmc_pkg::CNT_ONE;
               end
               qual_hi[c] = cnt_hi_q[c] + tmc_pkg::CNT_ONE >= depth; // [R11]
            end else begin
               cnt_hi_d[c] = tmc_pkg::CNT_ZERO;
            end
            if (sgt(lim[c+N], temp_d[c])) begin
               if (cnt_lo_q[c] < tmc_pkg::FQ_D3) begin
                  cnt_lo_d[c] = cnt_lo_q[c] + tmc_pkg::CNT_ONE;
               end
               qual_lo[c] = cnt_lo_q[c] + tmc_pkg::CNT_ONE >= depth; // [R11]
            end else begin
               cnt_lo_d[c] = tmc_pkg::CNT_ZERO;
            end
            // release needs 2 degrees of margin inside the limit
            if (qual_hi[c]) begin
               cmp_hi_d[c] = 1'b1;
            end else if ($signed({temp_d[c][7], temp_d[c]}) + tmc_pkg::HYST
                         <= $signed({lim[c][7], lim[c]})) begin
               cmp_hi_d[c] = 1'b0; // [R18]
            end
            if (qual_lo[c]) begin
               cmp_lo_d[c] = 1'b1;
            end else if ($signed({temp_d[c][7], temp_d[c]}) >=
                         $signed({lim[c+N][7], lim[c+N]}) + tmc_pkg::HYST) begin
               cmp_lo_d[c] = 1'b0; // [R18]
            end
         end
      end
   end

   // highest of the selected channels from the fresh pass
   always_comb begin
      highest_d = tmc_pkg::TEMP_MIN;
      for (int c = 0; c < N; c++) begin
         sel_temp[c] = pass_done ? temp_d[c] : temp_q[c];
         if (sel_q[c] && sgt(sel_temp[c], highest_d)) begin
            highest_d = sel_temp[c]; // [R01]
         end
      end
   end

   // set from a new pass wins over a clear by status read or ARA
   always_comb begin
      if (cmp_mode) begin
         alarm_d = |((cmp_hi_d | cmp_lo_d) & ~mask_q); // [R10] [R05]
      end else if (pass_done && |((qual_hi | qual_lo) & ~mask_q)) begin
         alarm_d = 1'b1; // [R05] [R19]
      end else if (rd_stat_hi || rd_stat_lo || ara_i) begin
         alarm_d = 1'b0; // [R19]
      end else begin
         alarm_d = alarm_q;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= wr_cfg && !oneshot_wr &&
                       req_i.wdata[tmc_pkg::CFG_POR]; // [R08]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst) begin
         cfg_q <= tmc_pkg::CFG_RST; // [R06] [R09] [R10]
      end else if (wr_cfg && !oneshot_wr) begin
         cfg_q <= cfg_wr_val; // [R14] [R13]
      end
   end

   // one-shot outside standby is dropped, the write still does nothing else
   always_ff @(posedge sys_clk_i) begin
      if (rst) begin
         oneshot_pend_q <= 1'b0;
      end else if (oneshot_wr && stop) begin
         oneshot_pend_q <= 1'b1; // [R15]
      end else if (start_pass) begin
         oneshot_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst) begin
         sel_q <= tmc_pkg::SEL_RST[3:0];
         mask_q <= tmc_pkg::MASK_RST; // [R03]
      end else begin
         if (wr_sel) begin
            sel_q <= req_i.wdata[3:0]; // [R20]
         end
         if (wr_mask) begin
            mask_q <= req_i.wdata[3:0];
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst) begin
         state_q <= tmc_pkg::TMC_ST_IDLE;
      end else begin
         case (state_q)
            tmc_pkg::TMC_ST_IDLE: begin
               if (start_pass) begin
                  state_q <= tmc_pkg::TMC_ST_WAIT;
               end
            end
            tmc_pkg::TMC_ST_WAIT: begin
               if (conv_i.done) begin
                  state_q <= tmc_pkg::TMC_ST_IDLE; // [R21]
               end
            end
            default: state_q <= tmc_pkg::TMC_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst) begin
         temp_q <= {N{tmc_pkg::TEMP_RST}};
         highest_q <= tmc_pkg::TEMP_MIN;
         cnt_hi_q <= '0;
         cnt_lo_q <= '0;
         cmp_hi_q <= '0;
         cmp_lo_q <= '0;
      end else begin
         if (pass_done) begin
            temp_q <= temp_d;
         end
         highest_q <= highest_d;
         cnt_hi_q <= cnt_hi_d;
         cnt_lo_q <= cnt_lo_d;
         cmp_hi_q <= cmp_hi_d;
         cmp_lo_q <= cmp_lo_d;
      end
   end

   // status clears on read; a qualified fault in the same cycle stays set
   always_ff @(posedge sys_clk_i) begin
      if (rst) begin
         stat_hi_q <= '0;
         stat_lo_q <= '0;
      end else begin
         stat_hi_q <= (rd_stat_hi ? '0 : stat_hi_q) | qual_hi; // [R04]
         stat_lo_q <= (rd_stat_lo ? '0 : stat_lo_q) | qual_lo; // [R04]
      end
   end

   // pin outputs and converter controls
   always_ff @(posedge sys_clk_i) begin
      if (rst) begin
         alarm_q <= 1'b0;
         thermal_alarm_out_o <= 1'b0;
         thermal_alarm_out_oe_o <= 1'b0;
         conv_start_o <= 1'b0;
         adc_enable_o <= 1'b0;
         timeout_en_o <= 1'b0;
         wide_range_format_o <= 1'b0;
      end else begin
         alarm_q <= alarm_d;
         thermal_alarm_out_o <= 1'b0;
         thermal_alarm_out_oe_o <= alarm_d; // [R05]
         conv_start_o <= start_pass; // [R13] [R21]
         adc_enable_o <= !stop || oneshot_pend_q; // [R06]
         timeout_en_o <= !cfg_q[tmc_pkg::CFG_TMO]; // [R09]
         wide_range_format_o <= wide; // [R12]
      end
   end

   // reads answer in two cycles so limit bytes come from the memory port;
   // the port is never gated by standby
   always_ff @(posedge sys_clk_i) begin
      if (rst) begin
         rd_d1_q <= 1'b0;
         addr_d1_q <= tmc_pkg::READ_ZERO;
         rvalid_o <= 1'b0;
         rdata_o <= tmc_pkg::READ_ZERO;
      end else begin
         rd_d1_q <= req_i.rd; // [R07]
         addr_d1_q <= req_i.addr;
         rvalid_o <= rd_d1_q;
         if (rd_d1_q) begin
            rdata_o <= rd_mux;
         end
      end
   end

   logic [7:0] stat_hi_cap_q;
   logic [7:0] stat_lo_cap_q;

   // status is captured before its clear-on-read takes effect
   always_ff @(posedge sys_clk_i) begin
      if (rst) begin
         stat_hi_cap_q <= tmc_pkg::READ_ZERO;
         stat_lo_cap_q <= tmc_pkg::READ_ZERO;
      end else begin
         stat_hi_cap_q <= {4'h0, stat_hi_q};
         stat_lo_cap_q <= {4'h0, stat_lo_q};
      end
   end

   always_comb begin
      rd_mux = tmc_pkg::READ_ZERO;
      if (addr_d1_q >= tmc_pkg::ADDR_LIM_BASE &&
          addr_d1_q <= tmc_pkg::ADDR_LIM_LAST) begin
         rd_mux = lim_rdata; // [R02]
      end else if (addr_d1_q <= tmc_pkg::ADDR_TEMP_LAST) begin
         rd_mux = temp_q[addr_d1_q[1:0]];
      end else begin
         case (addr_d1_q)
            tmc_pkg::ADDR_HIGHEST: rd_mux = highest_q;
            tmc_pkg::ADDR_SEL: rd_mux = tmc_pkg::SEL_RSVD | {4'h0, sel_q}; // [R20]
            tmc_pkg::ADDR_CFG: rd_mux = cfg_q;
            tmc_pkg::ADDR_STAT_HI: rd_mux = stat_hi_cap_q;
            tmc_pkg::ADDR_STAT_LO: rd_mux = stat_lo_cap_q;
            tmc_pkg::ADDR_MASK: rd_mux = {4'h0, mask_q};
            default: rd_mux = tmc_pkg::READ_ZERO;
         endcase
      end
   end

endmodule : tmc_regs

/* dv/tmc_regs_props.sv */
`timescale 1ns/1ps

module tmc_regs_props (
   input wire logic sys_clk_i, // system clock
   input wire logic reset_i, // sync reset
   input wire tmc_pkg::tmc_reg_req_t req_i, // register request
   input wire logic ara_i, // alert response done
   input wire tmc_pkg::tmc_conv_t conv_i, // converter results
   input wire logic [7:0] rdata_o, // read data
   input wire logic rvalid_o, // read valid
   input wire logic conv_start_o, // pass start
   input wire logic adc_enable_o, // converter on
   input wire logic timeout_en_o, // bus timeout on
   input wire logic wide_range_format_o, // wide coding
   input wire logic thermal_alarm_out_o, // alarm data
   input wire logic thermal_alarm_out_oe_o // alarm drive
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   logic stop_q;
   logic open_q;
   wire cfg_wr = req_i.wr && req_i.addr == tmc_pkg::ADDR_CFG;
   wire plain_wr = cfg_wr && !req_i.wdata[0] && !req_i.wdata[6];
   wire soft_wr = cfg_wr && req_i.wdata[6] && !req_i.wdata[0];
   wire shot_wr = cfg_wr && req_i.wdata[0];
   wire mask_wr = req_i.wr && req_i.addr == tmc_pkg::ADDR_MASK;

   // open_q is sticky: once unmasked we no longer know the alarm
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || soft_wr) begin
         stop_q <= 1'b0;
         open_q <= 1'b0;
      end else begin
         if (plain_wr) stop_q <= req_i.wdata[7];
         if (mask_wr) open_q <= open_q | (req_i.wdata[3:0] != 4'hF);
      end
   end

   sequence s_stop;
      plain_wr && req_i.wdata[7] ##1 !shot_wr;
   endsequence

   AST_RD_ANSWER:
   assert property (req_i.rd |-> ##2 rvalid_o)
      else $error("read not answered two cycles later");
   AST_RD_ONLY:
   assert property (rvalid_o |-> $past(req_i.rd, 2))
      else $error("read data valid without a read");
   AST_TIMEOUT_BIT:
   assert property (plain_wr |->
      ##2 timeout_en_o == !$past(req_i.wdata[5], 2))
      else $error("timeout enable does not follow bit 5");
   AST_WIDE_BIT:
   assert property (plain_wr |->
      ##2 wide_range_format_o == $past(req_i.wdata[1], 2))
      else $error("wide format does not follow bit 1");
   AST_SHOT_KEEPS:
   assert property (shot_wr |=>
      $stable({timeout_en_o, wide_range_format_o}) [*3])
      else $error("one-shot write changed other fields");
   AST_STANDBY_OFF:
   assert property (s_stop |-> ##1 !adc_enable_o)
      else $error("converter still on in standby");
   AST_RUN_ON:
   assert property (conv_i.done && !stop_q && !cfg_wr && !$past(soft_wr)
      |-> ##2 conv_start_o)
      else $error("no new pass after done while running");
   AST_SOFT_RESET:
   assert property (soft_wr |-> ##4 timeout_en_o && !wide_range_format_o)
      else $error("soft reset did not restore configuration");
   AST_POWER_UP:
   assert property ($fell(reset_i) |-> ##2 timeout_en_o && adc_enable_o)
      else $error("wrong outputs after reset release");
   AST_MASKED_START:
   assert property (!open_q && !$past(open_q, 2) |-> !thermal_alarm_out_oe_o)
      else $error("alarm driven while all channels masked");
endmodule : tmc_regs_props

bind tmc_regs tmc_regs_props u_tmc_regs_props (.sys_clk_i, .reset_i,
   .req_i, .ara_i, .conv_i, .rdata_o, .rvalid_o, .conv_start_o,
   .adc_enable_o, .timeout_en_o, .wide_range_format_o,
   .thermal_alarm_out_o, .thermal_alarm_out_oe_o);

/* dv/tmc_conv_model.sv */
`timescale 1ns/1ps

module tmc_conv_model (
   input wire logic sys_clk_i, // system clock
   input wire logic reset_i, // sync reset
   input wire logic start_i, // pass request
   input wire logic slow_i, // answer after a long pass
   input wire logic [3:0][8:0] temp_i, // temperatures to report
   output tmc_pkg::tmc_conv_t conv_o // pass results
);
   logic [4:0] cnt_q;
   logic busy_q;

   always_ff @(posedge sys_clk_i) begin
      conv_o.done <= 1'b0;
      // outside done the bus carries garbage, never stale results
      conv_o.temp <= ~temp_i;
      if (reset_i) begin
         busy_q <= 1'b0;
      end else if (start_i) begin
         busy_q <= 1'b1;
         cnt_q <= slow_i ? 5'd20 : 5'd2;
      end else if (busy_q) begin
         if (cnt_q == 5'd0) begin
            busy_q <= 1'b0;
            conv_o.done <= 1'b1;
            conv_o.temp <= temp_i;
         end else begin
            cnt_q <= cnt_q - 5'd1;
         end
      end
   end
endmodule : tmc_conv_model

/* dv/tmc_regs_tb.sv */
`timescale 1ns/1ps

module tmc_regs_tb;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   tmc_pkg::tmc_reg_req_t req_i = '0;
   logic ara_i = 1'b0;
   tmc_pkg::tmc_conv_t conv_i;
   logic [7:0] rdata_o;
   logic rvalid_o, conv_start_o, adc_enable_o, timeout_en_o;
   logic wide_range_format_o, thermal_alarm_out_o, thermal_alarm_out_oe_o;
   logic slow = 1'b0;
   logic [3:0][8:0] temp = {9'd60, 9'd50, 9'd90, 9'd30};
   int n_fail = 0;
   int compares = 0;
   int n_start = 0;

   always #2 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) if (conv_start_o === 1'b1) n_start++;

   tmc_regs u_tmc_regs (.sys_clk_i, .reset_i, .req_i, .ara_i, .conv_i,
      .rdata_o, .rvalid_o, .conv_start_o, .adc_enable_o, .timeout_en_o,
      .wide_range_format_o, .thermal_alarm_out_o, .thermal_alarm_out_oe_o);
   tmc_conv_model u_tmc_conv_model (.sys_clk_i, .reset_i,
      .start_i(conv_start_o), .slow_i(slow), .temp_i(temp),
      .conv_o(conv_i));

   task automatic give_verdict();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input string w, input logic [7:0] e,
                      input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", w, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk_i);
      req_i <= '0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e,
                     input string w);
      int i;
      @(posedge sys_clk_i);
      req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge sys_clk_i);
      req_i <= '0;
      i = 0;
      do begin
         @(negedge sys_clk_i);
         i++;
      end while (rvalid_o !== 1'b1 && i < 4);
      if (rvalid_o !== 1'b1) begin
         n_fail++;
         $display("[FAIL] %s rvalid_o expected 1 seen 0", w);
         give_verdict();
      end else chk(w, e, rdata_o);
   endtask : rd

   // ends one cycle after done, when the alarm has caught up
   task automatic pass_wait(input int n);
      int i;
      repeat (n) begin
         i = 0;
         do begin
            @(negedge sys_clk_i);
            i++;
         end while (conv_i.done !== 1'b1 && i < 200);
         if (conv_i.done !== 1'b1) begin
            n_fail++;
            $display("[FAIL] pass_done expected 1 seen 0");
            give_verdict();
         end
      end
      @(negedge sys_clk_i);
   endtask : pass_wait

   task automatic shot(input logic [8:0] t1);
      @(posedge sys_clk_i);
      temp[1] <= t1;
      wr(8'h13, 8'hA1);
      pass_wait(1);
   endtask : shot

   function automatic logic [7:0] lim(input int k);
      return k < 4 ? 8'h50 : 8'h00;
   endfunction : lim

   initial begin
      int s;
      repeat (3) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      rd(8'h12, 8'hFF, "sel");
      rd(8'h13, 8'h10, "cfg");
      rd(8'h34, 8'h0F, "mask");
      rd(8'h20, 8'h7F, "lim_hi");
      rd(8'h24, 8'h80, "lim_lo");
      rd(8'h50, 8'h00, "unmapped");
      chk("tmo", 8'h01, 8'(timeout_en_o));
      wr(8'h12, 8'h05);
      rd(8'h12, 8'hF5, "sel_wr");
      pass_wait(2);
      rd(8'h10, 8'h32, "highest");
      wr(8'h13, 8'h22);
      pass_wait(2);
      chk("tmo", 8'h00, 8'(timeout_en_o));
      chk("wide", 8'h01, 8'(wide_range_format_o));
      rd(8'h01, 8'h1A, "wide_t1");
      wr(8'h13, 8'h94);
      repeat (20) @(posedge sys_clk_i);
      s = n_start;
      for (int k = 0; k < 8; k++) wr(8'h20 + 8'(k), lim(k));
      for (int k = 0; k < 8; k++) rd(8'h20 + 8'(k), lim(k), "lim");
      chk("standby", 8'(s), 8'(n_start));
      chk("adc", 8'h00, 8'(adc_enable_o));
      rd(8'h13, 8'h94, "cfg_stop");
      wr(8'h34, 8'h00);
      slow <= 1'b1;
      shot(9'd90);
      slow <= 1'b0;
      chk("starts", 8'(s + 1), 8'(n_start));
      chk("alarm_q1", 8'h00, 8'(thermal_alarm_out_oe_o));
      chk("tmo_shot", 8'h01, 8'(timeout_en_o));
      rd(8'h13, 8'h94, "cfg_shot");
      shot(9'd90);
      chk("alarm_q2", 8'h01, 8'(thermal_alarm_out_oe_o));
      chk("alarm_data", 8'h00, 8'(thermal_alarm_out_o));
      rd(8'h32, 8'h02, "stat_hi");
      @(negedge sys_clk_i);
      chk("alarm_cmp", 8'h01, 8'(thermal_alarm_out_oe_o));
      shot(9'd79);
      chk("alarm_hyst", 8'h01, 8'(thermal_alarm_out_oe_o));
      shot(9'd78);
      chk("alarm_rel", 8'h00, 8'(thermal_alarm_out_oe_o));
      wr(8'h13, 8'h80);
      shot(9'd90);
      chk("alarm_int", 8'h01, 8'(thermal_alarm_out_oe_o));
      rd(8'h32, 8'h02, "stat_int");
      @(negedge sys_clk_i);
      chk("alarm_rdclr", 8'h00, 8'(thermal_alarm_out_oe_o));
      shot(9'd90);
      chk("alarm_again", 8'h01, 8'(thermal_alarm_out_oe_o));
      @(posedge sys_clk_i);
      ara_i <= 1'b1;
      @(posedge sys_clk_i);
      ara_i <= 1'b0;
      repeat (2) @(negedge sys_clk_i);
      chk("alarm_ara", 8'h00, 8'(thermal_alarm_out_oe_o));
      wr(8'h34, 8'h02);
      shot(9'd90);
      chk("alarm_mask", 8'h00, 8'(thermal_alarm_out_oe_o));
      // deeper queue codes: a cool pass first breaks the fault run
      wr(8'h34, 8'h00);
      for (int q = 0; q < 2; q++) begin
         wr(8'h13, q ? 8'h8C : 8'h88);
         shot(9'd78);
         repeat (q ? 5 : 3) shot(9'd90);
         chk("fq_short", 8'h00, 8'(thermal_alarm_out_oe_o));
         shot(9'd90);
         chk("fq_full", 8'h01, 8'(thermal_alarm_out_oe_o));
         rd(8'h32, 8'h02, "stat_fq");
      end
      wr(8'h13, 8'h60);
      repeat (3) @(posedge sys_clk_i);
      rd(8'h13, 8'h10, "cfg_por");
      rd(8'h12, 8'hFF, "sel_por");
      rd(8'h20, 8'h7F, "lim_por");
      rd(8'h34, 8'h0F, "mask_por");
      chk("tmo_por", 8'h01, 8'(timeout_en_o));
      give_verdict();
   end
endmodule : tmc_regs_tb
